// [rtl/rfo_top.sv]
// Purpose: Reference force-fault / monitor-bypass control and interrupt clearing
// Assumes: One clock; event and fault inputs come from logic on clk
// Notes: Registers on classic Wishbone, index = byte address / 4
`timescale 1ns/10ps
`include "rfo_regs.svh"
module rfo_top (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Wishbone slave
  input wire rfo_pkg::rfo_wb_req_t wb_req,
  output rfo_pkg::rfo_wb_rsp_t wb_rsp,
  // Reference status from the monitors
  input wire logic [3:0] ref_faulted,
  // Interrupt events, one-cycle pulses
  input wire rfo_pkg::rfo_irq_bank_t events,
  // Reference control
  output rfo_pkg::rfo_ref_ctl_t ref_ctl,
  // Clear pulses to loop and watchdog logic
  output logic loop_zero_clear,
  output logic loop_one_clear,
  output logic watchdog_alert_clear,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic ack_r;
  logic [31:0] rdat_r;
  logic access;
  logic wr;
  logic rd;
  logic [13:0] idx;
  logic [7:0] wbyte;

  // One request per ack; the cycle in which ack is high is never taken
  assign access = wb_req.cyc & wb_req.stb & ~ack_r;
  assign wr = access & wb_req.we & wb_req.sel[0];
  assign rd = access & ~wb_req.we;
  assign idx = wb_req.adr[15:2];
  assign wbyte = wb_req.dat[7:0];

  function automatic logic hit(input logic [13:0] a, input logic [13:0] b);
    hit = (a == b);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [3:0] force_fault_r;
  logic [3:0] bypass_r;
  logic [3:0] val_zero_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      force_fault_r <= `RFO_RST_NIBBLE;
    end else if (ce && wr && hit(idx, `RFO_IDX_FORCE_FAULT)) begin
      force_fault_r <= wbyte[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bypass_r <= `RFO_RST_NIBBLE;
    end else if (ce && wr && hit(idx, `RFO_IDX_MON_BYPASS)) begin
      bypass_r <= wbyte[3:0];
    end
  end

  // Autoclearing timeout: one-cycle pulse, suppressed for faulted references
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      val_zero_r <= `RFO_RST_NIBBLE;
    end else if (ce) begin
      if (wr && hit(idx, `RFO_IDX_VAL_TIMEOUT)) begin
        val_zero_r <= wbyte[3:0] & ~(force_fault_r | ref_faulted);
      end else begin
        val_zero_r <= `RFO_RST_NIBBLE;
      end
    end
  end

  assign ref_ctl.force_fault = force_fault_r;
  assign ref_ctl.monitor_bypass = bypass_r;
  assign ref_ctl.unusable = force_fault_r | ref_faulted;
  assign ref_ctl.validation_zero = val_zero_r;

  ////////////////////////////////////////////////////////////////////////////
  // Self-clearing clear registers

  logic [7:0] grp_clr_r;
  logic [7:0] sys_clr_r;
  logic [7:0] rab_clr_r;
  logic [7:0] rcd_clr_r;

  // Each holds a written one for a single cycle, then returns to zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      grp_clr_r <= `RFO_RST_BYTE;
      sys_clr_r <= `RFO_RST_BYTE;
      rab_clr_r <= `RFO_RST_BYTE;
      rcd_clr_r <= `RFO_RST_BYTE;
    end else if (ce) begin
      grp_clr_r <= `RFO_RST_BYTE;
      sys_clr_r <= `RFO_RST_BYTE;
      rab_clr_r <= `RFO_RST_BYTE;
      rcd_clr_r <= `RFO_RST_BYTE;
      if (wr && hit(idx, `RFO_IDX_GRP_CLEAR)) begin
        grp_clr_r <= wbyte & `RFO_GRP_BITS;
      end
      if (wr && hit(idx, `RFO_IDX_SYS_CLEAR)) begin
        sys_clr_r <= wbyte & `RFO_SYS_BITS;
      end
      if (wr && hit(idx, `RFO_IDX_RAB_CLEAR)) begin
        rab_clr_r <= wbyte & `RFO_PAIR_BITS;
      end
      if (wr && hit(idx, `RFO_IDX_RCD_CLEAR)) begin
        rcd_clr_r <= wbyte & `RFO_PAIR_BITS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Group expansion

  logic grp_all;
  logic grp_common;
  logic [7:0] wdog_grp;

  assign grp_all = grp_clr_r[`RFO_GRP_ALL];
  assign grp_common = grp_all | grp_clr_r[`RFO_GRP_COMMON];
  // Watchdog alert clear also drops the latched expiration bit
  assign wdog_grp = {4'h0, grp_clr_r[`RFO_GRP_WDOG], 3'h0};

  // Loop groups live in the loop logic; this block only signals them
  assign loop_zero_clear = grp_all | grp_clr_r[`RFO_GRP_LOOP0];
  assign loop_one_clear = grp_all | grp_clr_r[`RFO_GRP_LOOP1];
  assign watchdog_alert_clear = grp_all | grp_clr_r[`RFO_GRP_WDOG];

  ////////////////////////////////////////////////////////////////////////////
  // Latched monitor bits

  rfo_pkg::rfo_irq_bank_t mon;
  rfo_pkg::rfo_irq_bank_t clr;
  rfo_pkg::rfo_irq_bank_t mask_r;
  rfo_pkg::rfo_irq_bank_t events_m;

  logic rd_sys;
  logic rd_rab;
  logic rd_rcd;

  // Reading a monitor register clears it; the read returns the old value
  assign rd_sys = rd && hit(idx, `RFO_IDX_MON_SYS);
  assign rd_rab = rd && hit(idx, `RFO_IDX_MON_RAB);
  assign rd_rcd = rd && hit(idx, `RFO_IDX_MON_RCD);

  // Reserved positions never latch
  assign events_m.sys_nvm = events.sys_nvm & `RFO_SYS_BITS;
  assign events_m.ref_ab = events.ref_ab & `RFO_PAIR_BITS;
  assign events_m.ref_cd = events.ref_cd & `RFO_PAIR_BITS;

  // Same bit position clears same monitor bit; bits 6..4 PLL, 3 watchdog, 1..0 memory
  assign clr.sys_nvm = sys_clr_r | wdog_grp | {8{grp_common | rd_sys}};
  assign clr.ref_ab = rab_clr_r | {8{grp_common | rd_rab}};
  assign clr.ref_cd = rcd_clr_r | {8{grp_common | rd_rcd}};

  rfo_sticky #(
    .W(24)
  ) u_monitor (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .set_i(events_m),
    .clr_i(clr),
    .q(mon)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt masks

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_r <= '0;
    end else if (ce && wr) begin
      if (hit(idx, `RFO_IDX_MASK_SYS)) begin
        mask_r.sys_nvm <= wbyte & `RFO_SYS_BITS;
      end
      if (hit(idx, `RFO_IDX_MASK_RAB)) begin
        mask_r.ref_ab <= wbyte & `RFO_PAIR_BITS;
      end
      if (hit(idx, `RFO_IDX_MASK_RCD)) begin
        mask_r.ref_cd <= wbyte & `RFO_PAIR_BITS;
      end
    end
  end

  // Cleared monitor bit withdraws the request the cycle after the clear
  assign irq = |(mon & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and acknowledge

  logic [7:0] rbyte;

  always_comb begin
    rbyte = `RFO_RST_BYTE;
    unique case (idx)
      `RFO_IDX_FORCE_FAULT: rbyte = {4'h0, force_fault_r};
      `RFO_IDX_MON_BYPASS: rbyte = {4'h0, bypass_r};
      `RFO_IDX_MON_SYS: rbyte = mon.sys_nvm;
      `RFO_IDX_MON_RAB: rbyte = mon.ref_ab;
      `RFO_IDX_MON_RCD: rbyte = mon.ref_cd;
      `RFO_IDX_MASK_SYS: rbyte = mask_r.sys_nvm;
      `RFO_IDX_MASK_RAB: rbyte = mask_r.ref_ab;
      `RFO_IDX_MASK_RCD: rbyte = mask_r.ref_cd;
      // Clearing, timeout and unmapped indices read as zero
      default: rbyte = `RFO_RST_BYTE;
    endcase
  end

  // Every access, mapped or not, gets ack one edge after it is seen
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      rdat_r <= '0;
    end else if (ce) begin
      ack_r <= access;
      if (rd) begin
        rdat_r <= {24'h000000, rbyte};
      end else begin
        rdat_r <= '0;
      end
    end
  end

  assign wb_rsp.ack = ack_r;
  assign wb_rsp.dat = rdat_r;

endmodule // rfo_top

// [rtl/rfo_regs.svh]
// Purpose: Register indices, field positions, writable masks and reset values
// Assumes: Register index = byte address / 4; data in bits 7:0
// Notes: Definitions only
`ifndef RFO_REGS_SVH
`define RFO_REGS_SVH

// Register indices
`define RFO_IDX_VAL_TIMEOUT 14'h0a02
`define RFO_IDX_FORCE_FAULT 14'h0a03
`define RFO_IDX_MON_BYPASS 14'h0a04
`define RFO_IDX_GRP_CLEAR 14'h0a05
`define RFO_IDX_SYS_CLEAR 14'h0a06
`define RFO_IDX_RAB_CLEAR 14'h0a07
`define RFO_IDX_RCD_CLEAR 14'h0a08
`define RFO_IDX_MON_SYS 14'h0d08
`define RFO_IDX_MON_RAB 14'h0d09
`define RFO_IDX_MON_RCD 14'h0d0a
`define RFO_IDX_MASK_SYS 14'h0d18
`define RFO_IDX_MASK_RAB 14'h0d19
`define RFO_IDX_MASK_RCD 14'h0d1a

// Implemented bits per register
`define RFO_REF4_BITS 8'h0f
`define RFO_GRP_BITS 8'h8f
`define RFO_SYS_BITS 8'h7b
`define RFO_PAIR_BITS 8'h77

// Group clear fields
`define RFO_GRP_ALL 0
`define RFO_GRP_COMMON 1
`define RFO_GRP_LOOP0 2
`define RFO_GRP_LOOP1 3
`define RFO_GRP_WDOG 7

// System / nonvolatile fields
`define RFO_SYS_NVM_DONE 0
`define RFO_SYS_NVM_FAULT 1
`define RFO_SYS_WDOG 3
`define RFO_SYS_PLL_LOCKED 4
`define RFO_SYS_PLL_STABLE 5
`define RFO_SYS_PLL_UNLOCKED 6

// Reset values
`define RFO_RST_BYTE 8'h00
`define RFO_RST_NIBBLE 4'h0

`endif

// [rtl/rfo_pkg.sv]
// Purpose: Types shared by the reference control and interrupt clear block
// Assumes: Classic Wishbone, 32-bit data, byte addresses
// Notes: Constants live in rfo_regs.svh
package rfo_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rfo_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } rfo_wb_rsp_t;

  // Same layout for events, latched monitor bits, masks and clears
  typedef struct packed {
    logic [7:0] sys_nvm;
    logic [7:0] ref_ab;
    logic [7:0] ref_cd;
  } rfo_irq_bank_t;

  typedef struct packed {
    logic [3:0] force_fault;
    logic [3:0] monitor_bypass;
    logic [3:0] unusable;
    logic [3:0] validation_zero;
  } rfo_ref_ctl_t;

endpackage

// [rtl/rfo_sticky.sv]
// Purpose: Bank of latched interrupt monitor bits
// Assumes: Set and clear are single-cycle terms on clk
// Notes: A set in the clearing cycle survives
`timescale 1ns/10ps
module rfo_sticky #(
  parameter int W = 8
) (
  // Clock and control
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Set and clear terms
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  // Latched bits
  output logic [W-1:0] q
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  assign q_nxt = (q_r & ~clr_i) | set_i;
  assign q = q_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

endmodule // rfo_sticky

// [sim/rfo_top_sva.sv]
// Purpose: Assertions on the reference control and clear block
// Assumes: Sees rfo_top ports only; ce held high
// Notes: Bind at the foot
`timescale 1ns/10ps
module rfo_top_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Bus
  input wire rfo_pkg::rfo_wb_req_t wb_req,
  input wire rfo_pkg::rfo_wb_rsp_t wb_rsp,
  // Status and events
  input wire logic [3:0] ref_faulted,
  input wire rfo_pkg::rfo_irq_bank_t events,
  // Outputs
  input wire rfo_pkg::rfo_ref_ctl_t ref_ctl,
  input wire logic loop_zero_clear,
  input wire logic loop_one_clear,
  input wire logic watchdog_alert_clear,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  // Frozen cycles say nothing about timing
  default disable iff (!reset_n || !ce);
  //////////////////////////////////////////////////////////////////////////////
  a_unusable_or: assert property (
    ref_ctl.unusable == (ref_ctl.force_fault | ref_faulted))
    else $error("unusable mismatch");
  a_force_write: assert property ($changed(ref_ctl.force_fault) |-> wb_rsp.ack)
    else $error("force fault moved without write");
  a_bypass_write: assert property ($changed(ref_ctl.monitor_bypass) |-> wb_rsp.ack)
    else $error("bypass moved without write");
  a_loop_pulse: assert property (loop_zero_clear |=> !loop_zero_clear)
    else $error("loop clear not a pulse");
  a_wdog_ack: assert property (watchdog_alert_clear || loop_one_clear |-> wb_rsp.ack)
    else $error("clear pulse outside write");
  a_vz_ack: assert property (|ref_ctl.validation_zero |-> wb_rsp.ack)
    else $error("validation pulse outside write");
  a_vz_gate: assert property (
    (ref_ctl.validation_zero & $past(ref_ctl.unusable)) == 4'h0)
    else $error("validation on faulted ref");
  a_rsp_upper: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0)
    else $error("upper read bits set");
  a_irq_cause: assert property ($rose(irq) |-> $past(events) != 24'h0 || wb_rsp.ack)
    else $error("irq rose without cause");
endmodule // rfo_top_sva

bind rfo_top rfo_top_sva u_rfo_top_sva (.clk, .reset_n, .ce, .wb_req, .wb_rsp, .ref_faulted,
  .events, .ref_ctl, .loop_zero_clear, .loop_one_clear, .watchdog_alert_clear, .irq);

// [sim/tb_top.sv]
// Purpose: Self-checking bench for rfo_top
// Assumes: Wishbone index = byte address / 4
// Notes: ce tied high
`timescale 1ns/10ps
`include "rfo_regs.svh"
module tb_top;
  logic clk, reset_n, ce, irq, l0, l1, wd;
  logic [3:0] flt, vz;
  logic [2:0] pls;
  logic [31:0] rd;
  rfo_pkg::rfo_wb_req_t req;
  rfo_pkg::rfo_wb_rsp_t rsp;
  rfo_pkg::rfo_irq_bank_t ev;
  rfo_pkg::rfo_ref_ctl_t ctl;
  int miscompares = 0;
  int n_tests = 0;
  int cyc_n = 0;
  rfo_top u_rfo_top (.clk, .reset_n, .ce, .wb_req(req), .wb_rsp(rsp), .ref_faulted(flt),
    .events(ev), .ref_ctl(ctl), .loop_zero_clear(l0), .loop_one_clear(l1),
    .watchdog_alert_clear(wd), .irq);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [13:0] i, input logic [7:0] d);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {i, 2'b00}, sel: 4'hf, dat: {24'h0, d}};
    do @(posedge clk); while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    vz = ctl.validation_zero;
    pls = {l0, l1, wd};
    req <= '0;
  endtask
  task automatic rdc(input logic [13:0] i, input logic [31:0] e);
    wb(1'b0, i, 8'h00);
    chk(rd, e);
  endtask
  task automatic pulse(input logic [23:0] e);
    @(posedge clk);
    ev <= rfo_pkg::rfo_irq_bank_t'(e);
    @(posedge clk);
    ev <= '0;
    @(negedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdc(`RFO_IDX_FORCE_FAULT, 32'h0);
    rdc(`RFO_IDX_MON_BYPASS, 32'h0);
    wb(1'b1, `RFO_IDX_FORCE_FAULT, 8'hf5);
    chk(32'(ctl.force_fault), 32'h5);
    rdc(`RFO_IDX_FORCE_FAULT, 32'h5);
    flt <= 4'h2;
    @(negedge clk);
    chk(32'(ctl.unusable), 32'h7);
    wb(1'b1, `RFO_IDX_MON_BYPASS, 8'hfa);
    chk(32'(ctl.monitor_bypass), 32'ha);
    rdc(`RFO_IDX_MON_BYPASS, 32'ha);
    rdc(14'h3fff, 32'h0);
    wb(1'b1, `RFO_IDX_VAL_TIMEOUT, 8'hff);
    chk(32'(vz), 32'h8);
    wb(1'b1, `RFO_IDX_FORCE_FAULT, 8'h00);
    chk(32'(ctl.force_fault), 32'h0);
    flt <= 4'h0;
    wb(1'b1, `RFO_IDX_VAL_TIMEOUT, 8'h0f);
    chk(32'(vz), 32'hf);
  endtask
  // Each event bit against its own clear bit and against all the others
  task automatic t_clr();
    logic [13:0] ci;
    logic [13:0] mi;
    logic [7:0] im;
    logic [7:0] b;
    for (int k = 0; k < 3; k++) begin
      ci = (k == 0) ? `RFO_IDX_SYS_CLEAR : `RFO_IDX_RAB_CLEAR + 14'(k - 1);
      mi = `RFO_IDX_MON_SYS + 14'(k);
      im = (k == 0) ? `RFO_SYS_BITS : `RFO_PAIR_BITS;
      wb(1'b1, `RFO_IDX_MASK_SYS + 14'(k), 8'hff);
      for (int j = 0; j < 8; j++) begin
        b = 8'h01 << j;
        pulse({b, 16'h0} >> (8 * k));
        chk(32'(irq), 32'(im[j]));
        wb(1'b1, ci, im & ~b);
        @(negedge clk);
        chk(32'(irq), 32'(im[j]));
        wb(1'b1, ci, b);
        chk(32'(pls), 32'h0);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        rdc(ci, 32'h0);
      end
      wb(1'b1, `RFO_IDX_MASK_SYS + 14'(k), 8'h00);
      pulse(24'hffffff);
      chk(32'(irq), 32'h0);
      rdc(mi, 32'(im));
      rdc(mi, 32'h0);
    end
  endtask
  // Group bits: all, common, loop zero, loop one, watchdog
  task automatic t_grp();
    logic [7:0] g;
    logic [2:0] p;
    wb(1'b1, `RFO_IDX_MASK_SYS, 8'h08);
    for (int j = 0; j < 5; j++) begin
      g = (j == 4) ? 8'h80 : 8'(1 << j);
      p = (j == 0) ? 3'h7 : (j == 1) ? 3'h0 : (j == 4) ? 3'h1 : 3'(3'h4 >> (j - 2));
      pulse(24'hffffff);
      chk(32'(irq), 32'h1);
      wb(1'b1, `RFO_IDX_GRP_CLEAR, g);
      chk(32'(pls), 32'(p));
      @(negedge clk);
      // Loop groups leave this block's monitor bits alone
      chk(32'(irq), 32'(j == 2 || j == 3));
    end
    rdc(`RFO_IDX_MON_RAB, 32'h77);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Comparisons %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    req = '0;
    ev = '0;
    flt = 4'h0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_clr();
    t_grp();
    stop_test();
  end
  // Run needs about 400 cycles
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      miscompares++;
      stop_test();
    end
  end
endmodule // tb_top
